// File: include/esl_pkg.sv
/*
 * Constants, field layouts and shared functions of the serial encoder link node.
 * Assumes a 10 MHz system clock; link timing is derived from it.
 */
package esl_pkg;
	localparam int CLK_NS = 100;
	// static end-of-frame timeout
	localparam int TO_NS = 20000;
	localparam int TO_CYC = (TO_NS / CLK_NS < 1) ? 1 : TO_NS / CLK_NS;
	localparam int TO_CNT_W = 16;

	// process channel defaults
	localparam int DATA_W_DEF = 24;
	localparam int CRC_W_DEF = 6;
	localparam logic [15:0] CRC_POLY_DEF = 16'h0003;
	localparam int START_DLY_DEF = 0;
	localparam int FIFO_DEPTH_DEF = 8;

	// control frame layout, after its start bit
	localparam int CTRL_LEN = 16;
	localparam int CTRL_BCAST_POS = 15;
	localparam int CTRL_ID_LSB = 12;
	localparam int CTRL_ID_W = 3;
	localparam int CTRL_CMD_LSB = 4;
	localparam int CTRL_CMD_W = 8;
	localparam int CTRL_CRC_W = 4;
	localparam logic [15:0] CTRL_POLY = 16'h0003;
	localparam int REPLY_LEN = 1 + CTRL_CMD_W + CTRL_CRC_W;

	// input synchroniser bit positions
	localparam int SYN_CLK = 0;
	localparam int SYN_FWD = 1;
	localparam int SYN_POS = 2;
	localparam int SYN_W = 2 + CTRL_ID_W;

	localparam logic RETURN_IDLE = 1'b1;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SHIFT} esl_state_t;

	// serial crc over the low nbits of data, msb first
	function automatic logic [15:0] esl_crc(input logic [63:0] data, input int nbits,
		input logic [15:0] poly, input int w);
		logic [15:0] crc;
		logic fb;
		crc = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			if (i < nbits) begin
				fb = data[i] ^ crc[w-1];
				crc = {crc[14:0], 1'b0};
				if (fb) begin
					crc = crc ^ poly;
				end
			end
		end
		for (int j = 0; j < 16; j++) begin
			if (j >= w) begin
				crc[j] = 1'b0;
			end
		end
		return crc;
	endfunction
endpackage

// File: hdl/esl_sync.sv
/*
 * Two flip-flop synchroniser for a group of unrelated level inputs.
 * Assumes each bit is independent; no word coherence is promised.
 */
module esl_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= '1;
			q <= '1;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // esl_sync

// File: hdl/esl_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; the reader may stall so the writer sees full.
 */
module esl_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];

	function automatic logic [AW-1:0] adv(input logic [AW-1:0] p);
		return (p == AW'(D - 1)) ? '0 : p + 1'b1;
	endfunction

	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_r <= adv(wr_r);
			end
			if (pop) begin
				rd_r <= adv(rd_r);
			end
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt < (AW + 1)'(D));
		end
	end
endmodule // esl_fifo

// File: hdl/esl_node.sv
/*
 * Slave node of a synchronous serial encoder link: frame shifter, chain pass-through,
 * control frame receiver and timeout. Assumes the link clock is far slower than
 * CLK_SYS (several samples per half period) and arrives unsynchronised.
 */
module esl_node
	import esl_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEF,
	parameter int CRC_W = CRC_W_DEF,
	parameter logic [15:0] CRC_POLY = CRC_POLY_DEF,
	parameter int START_DLY = START_DLY_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
	parameter bit ACT_EN = 1'b0
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic NODE_CLOCK_INPUT,
	input wire logic NODE_FORWARD_INPUT,
	output logic NODE_RETURN_OUTPUT,
	input wire logic [CTRL_ID_W-1:0] NODE_POSITION,
	input wire logic SENS_VALID,
	output logic SENS_READY,
	input wire logic [DATA_W-1:0] SENS_DATA,
	output logic LATCH,
	output logic FRAME_BUSY,
	output logic ACT_VALID,
	output logic [DATA_W-1:0] ACT_DATA,
	output logic ACT_CRC_ERR,
	output logic CMD_VALID,
	output logic CMD_BCAST,
	output logic [CTRL_CMD_W-1:0] CMD_CODE,
	output logic CTRL_CRC_ERR
);
	localparam int CH_W = DATA_W + CRC_W;
	localparam int TX_W = 3 + START_DLY + CH_W;
	localparam int TXC_W = $clog2(TX_W + 1);

	logic [SYN_W-1:0] syn_q;
	logic clk_s;
	logic clk_d_r;
	logic fwd_s;
	logic rise;
	logic fall;
	esl_state_t state_r;
	logic [TX_W-1:0] tx_r;
	logic [TX_W-1:0] tx_nxt;
	logic [TXC_W-1:0] tx_cnt_r;
	logic fwd_bit_r;
	logic [CH_W-1:0] rx_r;
	logic [TO_CNT_W-1:0] to_cnt_r;
	logic timeout;
	logic cdm;
	logic [DATA_W-1:0] hold_r;
	logic fifo_valid;
	logic fifo_pop;
	logic [DATA_W-1:0] fifo_data;
	logic [DATA_W-1:0] chan_data;
	logic [15:0] chan_crc;
	logic [CTRL_ID_W-1:0] id_r;
	logic [CTRL_LEN-1:0] ctrl_r;
	logic [4:0] ctrl_cnt_r;
	logic [CTRL_LEN-1:0] ctrl_frame;
	logic ctrl_done;
	logic ctrl_ok;
	logic ctrl_hit;
	logic [REPLY_LEN-1:0] reply_r;
	logic [3:0] reply_cnt_r;
	logic cds;
	logic [15:0] act_crc;
	logic [15:0] cmd_crc;
	logic [15:0] reply_crc;

	esl_sync #(
		.W(SYN_W)
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.d({NODE_POSITION, NODE_FORWARD_INPUT, NODE_CLOCK_INPUT}),
		.q(syn_q)
	);

	assign clk_s = syn_q[SYN_CLK];
	assign fwd_s = syn_q[SYN_FWD];
	assign rise = clk_s && !clk_d_r;
	assign fall = !clk_s && clk_d_r;

	esl_fifo #(
		.W(DATA_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.in_valid(SENS_VALID),
		.in_ready(SENS_READY),
		.in_data(SENS_DATA),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// one sensor word drained per frame at the latch edge, else repeat the last
	assign fifo_pop = (state_r == ST_ARMED) && rise && fifo_valid;
	assign chan_data = fifo_valid ? fifo_data : hold_r;
	assign chan_crc = esl_crc(64'(chan_data), DATA_W, CRC_POLY, CRC_W);
	assign cds = (reply_cnt_r != '0) ? reply_r[REPLY_LEN-1] : 1'b0;

	always_comb begin
		tx_nxt = '0;
		tx_nxt[CH_W-1:0] = {chan_data, ~chan_crc[CRC_W-1:0]};
		tx_nxt[CH_W] = cds;
		tx_nxt[CH_W+1] = 1'b1;
		// ack and the processing delay zeros sit above the start bit
	end

	assign timeout = (state_r != ST_IDLE) && (to_cnt_r == TO_CNT_W'(TO_CYC - 1));
	// controller holds the clock low through the timeout to send a one
	assign cdm = !clk_s;

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			clk_d_r <= 1'b1;
		end else begin
			clk_d_r <= clk_s;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (fall) begin
						state_r <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (timeout) begin
						state_r <= ST_IDLE;
					end else if (rise) begin
						state_r <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (timeout) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			to_cnt_r <= '0;
		end else if (state_r == ST_IDLE || rise || fall) begin
			to_cnt_r <= '0;
		end else if (!timeout) begin
			to_cnt_r <= to_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			hold_r <= '0;
		end else if (fifo_pop) begin
			hold_r <= fifo_data;
		end
	end

	// own channel first, then the predecessor's bits one clock behind
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			tx_r <= '0;
			tx_cnt_r <= '0;
			NODE_RETURN_OUTPUT <= RETURN_IDLE;
		end else if (state_r == ST_ARMED && rise) begin
			tx_r <= tx_nxt;
			tx_cnt_r <= TXC_W'(TX_W);
		end else if (state_r == ST_SHIFT && timeout) begin
			tx_cnt_r <= '0;
			NODE_RETURN_OUTPUT <= RETURN_IDLE;
		end else if (state_r == ST_SHIFT && rise) begin
			if (tx_cnt_r != '0) begin
				NODE_RETURN_OUTPUT <= tx_r[TX_W-1];
				tx_r <= {tx_r[TX_W-2:0], 1'b0};
				tx_cnt_r <= tx_cnt_r - 1'b1;
			end else begin
				NODE_RETURN_OUTPUT <= fwd_bit_r;
			end
		end else if (state_r == ST_IDLE) begin
			NODE_RETURN_OUTPUT <= RETURN_IDLE;
		end
	end

	// forward input feeds both the pass-through bit and the actuator window
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			fwd_bit_r <= 1'b0;
			rx_r <= '0;
		end else if (state_r == ST_SHIFT && fall) begin
			fwd_bit_r <= fwd_s;
			rx_r <= {rx_r[CH_W-2:0], fwd_s};
		end
	end

	assign act_crc = esl_crc(64'(rx_r[CH_W-1:CRC_W]), DATA_W, CRC_POLY, CRC_W);

	// actuator channel: last bits clocked in before the timeout; off when tied low
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			ACT_VALID <= 1'b0;
			ACT_CRC_ERR <= 1'b0;
			ACT_DATA <= '0;
		end else begin
			ACT_VALID <= 1'b0;
			ACT_CRC_ERR <= 1'b0;
			if (ACT_EN && state_r == ST_SHIFT && timeout) begin
				if (~rx_r[CRC_W-1:0] == act_crc[CRC_W-1:0]) begin
					ACT_VALID <= 1'b1;
					ACT_DATA <= rx_r[CH_W-1:CRC_W];
				end else begin
					ACT_CRC_ERR <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			LATCH <= 1'b0;
			FRAME_BUSY <= 1'b0;
		end else begin
			LATCH <= (state_r == ST_ARMED) && rise;
			FRAME_BUSY <= (state_r != ST_IDLE) && !timeout;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			id_r <= '0;
		end else begin
			id_r <= syn_q[SYN_POS+CTRL_ID_W-1:SYN_POS];
		end
	end

	// control frame: a one starts it, then CTRL_LEN bits, one per frame
	assign ctrl_frame = {ctrl_r[CTRL_LEN-2:0], cdm};
	assign ctrl_done = timeout && (ctrl_cnt_r == 5'd1);
	assign cmd_crc = esl_crc(64'(ctrl_frame[CTRL_LEN-1:CTRL_CRC_W]), CTRL_LEN - CTRL_CRC_W,
		CTRL_POLY, CTRL_CRC_W);
	assign ctrl_ok = (~ctrl_frame[CTRL_CRC_W-1:0] == cmd_crc[CTRL_CRC_W-1:0]);
	assign reply_crc = ~esl_crc(64'(ctrl_frame[CTRL_CMD_LSB+CTRL_CMD_W-1:CTRL_CMD_LSB]),
		CTRL_CMD_W, CTRL_POLY, CTRL_CRC_W);
	assign ctrl_hit = ctrl_frame[CTRL_BCAST_POS] ||
		(ctrl_frame[CTRL_ID_LSB+CTRL_ID_W-1:CTRL_ID_LSB] == id_r);

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			ctrl_r <= '0;
			ctrl_cnt_r <= '0;
		end else if (timeout) begin
			if (ctrl_cnt_r != '0) begin
				ctrl_r <= ctrl_frame;
				ctrl_cnt_r <= ctrl_cnt_r - 1'b1;
			end else if (cdm) begin
				ctrl_cnt_r <= 5'(CTRL_LEN);
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			CMD_VALID <= 1'b0;
			CMD_BCAST <= 1'b0;
			CMD_CODE <= '0;
			CTRL_CRC_ERR <= 1'b0;
		end else begin
			CMD_VALID <= 1'b0;
			CTRL_CRC_ERR <= 1'b0;
			if (ctrl_done && !ctrl_ok) begin
				CTRL_CRC_ERR <= 1'b1;
			end else if (ctrl_done && ctrl_hit) begin
				CMD_VALID <= 1'b1;
				CMD_BCAST <= ctrl_frame[CTRL_BCAST_POS];
				CMD_CODE <= ctrl_frame[CTRL_CMD_LSB+CTRL_CMD_W-1:CTRL_CMD_LSB];
			end
		end
	end

	// reply on the slave control bit: start, echoed command, inverted crc
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			reply_r <= '0;
			reply_cnt_r <= '0;
		end else if (ctrl_done && ctrl_ok && ctrl_hit && !ctrl_frame[CTRL_BCAST_POS]) begin
			reply_r <= {1'b1, ctrl_frame[CTRL_CMD_LSB+CTRL_CMD_W-1:CTRL_CMD_LSB],
				reply_crc[CTRL_CRC_W-1:0]};
			reply_cnt_r <= 4'(REPLY_LEN);
		end else if (state_r == ST_ARMED && rise && reply_cnt_r != '0) begin
			reply_r <= {reply_r[REPLY_LEN-2:0], 1'b0};
			reply_cnt_r <= reply_cnt_r - 1'b1;
		end
	end
endmodule // esl_node

// File: tb/esl_node_monitor.sv
/* Checker of the link node, bound to its top ports.
   Assumes CLK_SYS at 100 ns and a timeout near 200 cycles. */
module esl_node_monitor (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic NODE_CLOCK_INPUT,
	input wire logic NODE_RETURN_OUTPUT,
	input wire logic SENS_READY,
	input wire logic LATCH,
	input wire logic FRAME_BUSY,
	input wire logic CMD_VALID,
	input wire logic CTRL_CRC_ERR
);
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_q_r;
	logic [7:0] since_edge_r;
	logic [7:0] since_rise_r;
	// age of the last raw link edge and rise, saturating
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			clk_q_r <= 1'b1;
			since_edge_r <= 8'hFF;
			since_rise_r <= 8'hFF;
		end else begin
			clk_q_r <= NODE_CLOCK_INPUT;
			since_edge_r <= (NODE_CLOCK_INPUT != clk_q_r) ? 8'h00 :
				(since_edge_r == 8'hFF) ? 8'hFF : since_edge_r + 8'h01;
			since_rise_r <= (NODE_CLOCK_INPUT && !clk_q_r) ? 8'h00 :
				(since_rise_r == 8'hFF) ? 8'hFF : since_rise_r + 8'h01;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	property p_ret_edge;
		$changed(NODE_RETURN_OUTPUT) |-> (since_rise_r inside {[8'h01:8'h06]}) ||
			(NODE_RETURN_OUTPUT && since_edge_r >= 8'hC3);
	endproperty
	a_ret_edge: assert property (p_ret_edge) else $error("return moved off a rise");
	property p_timeout;
		since_edge_r == 8'hD2 |-> NODE_RETURN_OUTPUT && !FRAME_BUSY;
	endproperty
	a_timeout: assert property (p_timeout) else $error("frame not closed");
	property p_idle_high;
		!FRAME_BUSY && !$past(FRAME_BUSY) |-> NODE_RETURN_OUTPUT;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("return low in idle");
	property p_latch_pulse;
		LATCH |=> !LATCH;
	endproperty
	a_latch_pulse: assert property (p_latch_pulse) else $error("latch too long");
	property p_latch_time;
		LATCH |-> FRAME_BUSY && (since_rise_r inside {[8'h01:8'h06]});
	endproperty
	a_latch_time: assert property (p_latch_time) else $error("latch off the rise");
	property p_cmd_time;
		CMD_VALID |-> since_edge_r inside {[8'hC3:8'hD2]};
	endproperty
	a_cmd_time: assert property (p_cmd_time) else $error("command off timeout");
	property p_cmd_pulse;
		CMD_VALID |=> !CMD_VALID [*8];
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("command repeated");
	property p_err_time;
		CTRL_CRC_ERR |-> !CMD_VALID && (since_edge_r inside {[8'hC3:8'hD2]});
	endproperty
	a_err_time: assert property (p_err_time) else $error("crc error misplaced");
	property p_rst_idle;
		disable iff (1'b0) !RSTN |=> NODE_RETURN_OUTPUT && !SENS_READY && !LATCH;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("not idle in reset");
endmodule // esl_node_monitor

// File: tb/esl_ctrl_model.sv
/* Behavioural link controller: framed link clock, forward data, late return sampling.
   Assumes the node's return bit settles within 750 ns of a rising link edge. */
module esl_ctrl_model (
	output logic link_clk,
	output logic fwd,
	input wire logic ret
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		link_clk = 1'b1;
		fwd = 1'b0;
	end
	task automatic xfer(input int n, input logic [63:0] fv, input logic cdm,
		output logic [63:0] rx);
		rx = 64'h0;
		#37 link_clk = 1'b0;
		#400 link_clk = 1'b1;
		for (int i = 1; i <= n; i++) begin
			#400 link_clk = 1'b0;
			#350;
			if (i > 1) begin
				rx = {rx[62:0], ret};
			end
			#50 link_clk = 1'b1;
			fwd = fv[i];
		end
		#750 rx = {rx[62:0], ret};
		// control bit is the inverse of the clock level held through the timeout
		#50 link_clk = ~cdm;
		#22000 link_clk = 1'b1;
		// frame length a whole number of system clocks
		#1963;
	endtask
endmodule // esl_ctrl_model

// File: tb/tb_encoder_serial_link.sv
/* Self-checking bench of the link node: reset, fifo, chain, control frames.
   Assumes the monitor and the controller model are compiled first. */
module tb_encoder_serial_link;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rstn, link_clk, fwd, ret, sens_valid, sens_ready, latch, busy;
	logic cmd_valid, cmd_bcast, ctrl_err, act_valid, act_err;
	logic [23:0] act_data;
	logic [2:0] pos;
	logic [23:0] sens_data;
	logic [7:0] cmd_code;
	logic [8:0] last_cmd;
	int fail_count = 0;
	int num_checks = 0;
	int n_lat = 0;
	int n_cmd = 0;
	int n_err = 0;
	int n_act = 0;
	esl_node uut (.CLK_SYS(clk_sys), .RSTN(rstn), .NODE_CLOCK_INPUT(link_clk),
		.NODE_FORWARD_INPUT(fwd), .NODE_RETURN_OUTPUT(ret), .NODE_POSITION(pos),
		.SENS_VALID(sens_valid), .SENS_READY(sens_ready), .SENS_DATA(sens_data),
		.LATCH(latch), .FRAME_BUSY(busy), .ACT_VALID(act_valid), .ACT_DATA(act_data),
		.ACT_CRC_ERR(act_err),
		.CMD_VALID(cmd_valid), .CMD_BCAST(cmd_bcast), .CMD_CODE(cmd_code),
		.CTRL_CRC_ERR(ctrl_err));
	esl_ctrl_model link (.link_clk(link_clk), .fwd(fwd), .ret(ret));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		n_lat += (latch === 1'b1);
		n_err += (ctrl_err === 1'b1);
		n_act += (act_valid !== 1'b0) + (act_err !== 1'b0);
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			last_cmd = {cmd_bcast, cmd_code};
		end
	end
	function automatic logic [15:0] ref_crc(input logic [23:0] d, input int n, input int w);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((d[i] ^ c[w - 1]) ? 16'h0003 : 16'h0000);
		end
		return c & ((16'h0001 << w) - 16'h0001);
	endfunction
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic frame(input logic cdm, input logic [63:0] fv, output logic [63:0] rx);
		int l0;
		l0 = n_lat;
		link.xfer(36, fv, cdm, rx);
		check(rx[35:34], 2'b01, "ack and start");
		check(rx[8:3], ~ref_crc(rx[32:9], 24, 6) & 16'h003F, "channel crc");
		check(rx[2:0], {fv[33], fv[34], fv[35]}, "pass through");
		check(ret, 1'b1, "idle after timeout");
		check(64'(n_lat - l0), 64'h1, "one latch");
	endtask
	task automatic t_fifo();
		logic [63:0] rx;
		int n;
		n = 0;
		repeat (12) begin
			@(negedge clk_sys);
			sens_valid = sens_ready;
			sens_data = {8'h5A, 8'(n), 8'hC3};
			n += (sens_ready === 1'b1);
		end
		@(negedge clk_sys);
		sens_valid = 1'b0;
		check(64'(n), 64'h8, "words until full");
		check(sens_ready, 1'b0, "fifo full");
		for (int k = 0; k < 9; k++) begin
			frame(1'b0, 64'h0, rx);
			check(rx[32:9], {8'h5A, 8'((k < 8) ? k : 7), 8'hC3}, "channel data");
		end
		check(sens_ready, 1'b1, "fifo drained");
		check(64'(n_act), 64'h0, "no actuator result");
		check(act_data, 24'h000000, "actuator data untouched");
	endtask
	task automatic t_ctrl(input logic bc, input logic [2:0] id, input logic [7:0] cmd,
		input logic bad);
		logic [63:0] rx;
		logic [15:0] c;
		logic [16:0] bits;
		logic [12:0] cds;
		logic ok;
		int c0;
		int e0;
		c0 = n_cmd;
		e0 = n_err;
		ok = !bad && (bc || id == 3'h5);
		c = ref_crc({12'h000, bc, id, cmd}, 12, 4);
		bits = {1'b1, bc, id, cmd, ~c[3:0] ^ {3'h0, bad}};
		for (int i = 16; i >= 0; i--) begin
			frame(bits[i], 64'h0, rx);
		end
		check(64'(n_cmd - c0), 64'(ok), "command taken");
		check(64'(n_err - e0), 64'(bad), "control crc error");
		if (ok) begin
			check(last_cmd, {bc, cmd}, "command fields");
		end
		c = ref_crc({16'h0000, cmd}, 8, 4);
		for (int i = 12; i >= 0; i--) begin
			frame(1'b0, 64'h0, rx);
			cds[i] = rx[33];
		end
		check(cds, (ok && !bc) ? {1'b1, cmd, ~c[3:0]} : 13'h0000, "slave reply");
	endtask
	initial begin
		logic [63:0] rx;
		rstn = 1'b0;
		sens_valid = 1'b0;
		sens_data = 24'h000000;
		pos = 3'h5;
		repeat (20) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(ret, 1'b1, "return idle");
		check(busy, 1'b0, "no frame open");
		check(sens_ready, 1'b1, "fifo ready");
		t_fifo();
		frame(1'b0, {28'h0, 3'h5, 33'h0}, rx);
		t_ctrl(1'b0, 3'h5, 8'h3C, 1'b0);
		t_ctrl(1'b1, 3'h2, 8'hA1, 1'b0);
		t_ctrl(1'b0, 3'h2, 8'h5E, 1'b0);
		t_ctrl(1'b0, 3'h5, 8'h77, 1'b1);
		summarize();
	end
	initial begin
		#9500000;
		fail_count++;
		$display("wrong value at %0t: run did not finish", $time);
		summarize();
	end
endmodule // tb_encoder_serial_link
bind esl_node esl_node_monitor mon (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.NODE_CLOCK_INPUT(NODE_CLOCK_INPUT), .NODE_RETURN_OUTPUT(NODE_RETURN_OUTPUT),
	.SENS_READY(SENS_READY), .LATCH(LATCH), .FRAME_BUSY(FRAME_BUSY),
	.CMD_VALID(CMD_VALID), .CTRL_CRC_ERR(CTRL_CRC_ERR));
